// >>> core/alu_compute.sv
/*
 * Combinational arithmetic/logic core: result plus carry, nibble carry
 * and zero, and which flags the operation touches.
 * Assumes operands are stable within the cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module alu_compute
	import alu_pkg::*;
(
	input  wire alu_pkg::alu_op_e op_i,
	input  wire alu_pkg::byte_t   acc_i,
	input  wire alu_pkg::byte_t   opnd_i,
	input  wire logic [2:0]       bit_sel_i,
	input  wire logic             carry_i,
	output alu_pkg::byte_t        result_o,
	output logic                  carry_o,
	output logic                  nibble_o,
	output logic                  zero_o,
	output logic                  upd_c_o,
	output logic                  upd_dc_o,
	output logic                  upd_z_o
);
	logic [8:0] sum;
	logic [4:0] nib;

	// Two's complement: subtract is opnd + ~acc + 1, so carry is inverted borrow
	always_comb
	begin
		sum      = 9'h000;
		nib      = 5'h00;
		result_o = opnd_i;
		carry_o  = carry_i;
		upd_c_o  = 1'b0;
		upd_dc_o = 1'b0;
		upd_z_o  = 1'b0;
		unique case (op_i)
			OP_ADD:
			begin
				sum      = {1'b0, opnd_i} + {1'b0, acc_i};
				nib      = {1'b0, opnd_i[3:0]} + {1'b0, acc_i[3:0]};
				result_o = sum[7:0];
				carry_o  = sum[8];
				upd_c_o  = 1'b1;
				upd_dc_o = 1'b1;
				upd_z_o  = 1'b1;
			end
			OP_SUB:
			begin
				sum      = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
				nib      = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
				result_o = sum[7:0];
				carry_o  = sum[8];
				upd_c_o  = 1'b1;
				upd_dc_o = 1'b1;
				upd_z_o  = 1'b1;
			end
			OP_AND:  begin result_o = acc_i & opnd_i; upd_z_o = 1'b1; end
			OP_OR:   begin result_o = acc_i | opnd_i; upd_z_o = 1'b1; end
			OP_XOR:  begin result_o = acc_i ^ opnd_i; upd_z_o = 1'b1; end
			OP_COMF: begin result_o = ~opnd_i; upd_z_o = 1'b1; end
			OP_INC:  begin result_o = opnd_i + 8'h01; upd_z_o = 1'b1; end
			OP_DEC:  begin result_o = opnd_i - 8'h01; upd_z_o = 1'b1; end
			OP_RLF:
			begin
				result_o = {opnd_i[6:0], carry_i};
				carry_o  = opnd_i[7];
				upd_c_o  = 1'b1;
			end
			OP_RRF:
			begin
				result_o = {carry_i, opnd_i[7:1]};
				carry_o  = opnd_i[0];
				upd_c_o  = 1'b1;
			end
			OP_SWAP: result_o = {opnd_i[3:0], opnd_i[7:4]};
			OP_MOVF: begin result_o = opnd_i; upd_z_o = 1'b1; end
			OP_CLR:  begin result_o = 8'h00; upd_z_o = 1'b1; end
			OP_MOVW: result_o = acc_i;
			OP_BCLR: result_o = opnd_i & ~(8'h01 << bit_sel_i);
			OP_BSET: result_o = opnd_i | (8'h01 << bit_sel_i);
		endcase
		nibble_o = nib[4];
		zero_o   = (result_o == 8'h00);
	end

endmodule

`default_nettype wire

// >>> core/alu_params.svh
/*
 * Constants for the arithmetic datapath and condition-flag register:
 * the register offset, bit positions, reset values and the one-cycle timing.
 * Assumes inclusion by bare name from core design files.
 */
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

`define COND_FLAGS_ADDR      5'h03
`define BIT_CARRY            0
`define BIT_NIBBLE_CARRY     1
`define BIT_ZERO             2
`define BIT_POWERDOWN        3
`define BIT_TIMEOUT          4
`define BIT_PAGE_LOW         5
`define BIT_PAGE_HIGH        6
`define BIT_SPARE_PAGE       7
`define PAGE_BITS_RESET      3'h0
`define SLEEP_FLAGS_RESET    2'h3
`define ARITH_FLAGS_RESET    3'h0
`define PAGE_WORDS           12'h200
`define OP_CYCLES            1

`endif

// >>> core/alu_pkg.sv
/*
 * Types shared by the datapath: operation codes and the byte type.
 * Assumes the decoder drives these codes one instruction per clock.
 */
package alu_pkg;

	typedef enum logic [3:0] {
		OP_ADD   = 4'h0,
		OP_SUB   = 4'h1,
		OP_AND   = 4'h2,
		OP_OR    = 4'h3,
		OP_XOR   = 4'h4,
		OP_COMF  = 4'h5,
		OP_INC   = 4'h6,
		OP_DEC   = 4'h7,
		OP_RLF   = 4'h8,
		OP_RRF   = 4'h9,
		OP_SWAP  = 4'ha,
		OP_MOVF  = 4'hb,
		OP_CLR   = 4'hc,
		OP_MOVW  = 4'hd,
		OP_BCLR  = 4'he,
		OP_BSET  = 4'hf
	} alu_op_e;

	typedef logic [7:0] byte_t;

endpackage

// >>> core/alu_status_flags.sv
/*
 * Accumulator, condition-flag register and datapath for one instruction
 * per clock. Holds the 8-bit accumulator and the flag register at 03h.
 * Assumes the decoder supplies op, operand, file address and destination
 * each cycle, and the file memory accepts the write strobe for non-flag
 * addresses.
 */
`timescale 1ns/10ps
`default_nettype none
`include "alu_params.svh"

module alu_status_flags
(
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             exec_i,
	input  wire alu_pkg::alu_op_e op_i,
	input  wire logic             use_const_i,
	input  wire alu_pkg::byte_t   const_i,
	input  wire logic [4:0]       file_addr_i,
	input  wire alu_pkg::byte_t   file_rdata_i,
	input  wire logic             dest_file_i,
	input  wire logic [2:0]       bit_sel_i,
	input  wire logic             wdt_timeout_i,
	input  wire logic             sleep_i,
	input  wire logic             clrwdt_i,
	output alu_pkg::byte_t        acc_o,
	output alu_pkg::byte_t        flags_o,
	output alu_pkg::byte_t        file_wdata_o,
	output logic                  file_we_o,
	output logic [4:0]            file_waddr_o,
	output logic [10:0]           page_base_o
);
	import alu_pkg::*;

	byte_t      acc_reg;
	byte_t      flags_reg;
	byte_t      wdata_reg;
	logic       we_reg;
	logic [4:0] waddr_reg;
	logic [10:0] page_reg;
	byte_t      opnd;
	byte_t      src;
	byte_t      result;
	logic       c_new;
	logic       dc_new;
	logic       z_new;
	logic       upd_c;
	logic       upd_dc;
	logic       upd_z;
	logic       is_flag_dst;
	logic       dst_file;
	byte_t      flags_next;

	// Operand: the flag register is served locally, the accumulator never is
	assign src  = (file_addr_i == `COND_FLAGS_ADDR) ? flags_reg : file_rdata_i;
	assign opnd = use_const_i ? const_i : src;
	// Move to file and bit ops always target the file
	assign dst_file    = dest_file_i || (op_i == OP_MOVW) || (op_i == OP_BCLR)
	                     || (op_i == OP_BSET);
	assign is_flag_dst = exec_i && dst_file && !use_const_i
	                     && (file_addr_i == `COND_FLAGS_ADDR);

	alu_compute u_compute
	(
		.op_i      (op_i),
		.acc_i     (acc_reg),
		.opnd_i    (opnd),
		.bit_sel_i (bit_sel_i),
		.carry_i   (flags_reg[`BIT_CARRY]),
		.result_o  (result),
		.carry_o   (c_new),
		.nibble_o  (dc_new),
		.zero_o    (z_new),
		.upd_c_o   (upd_c),
		.upd_dc_o  (upd_dc),
		.upd_z_o   (upd_z)
	);

	// Next flag value: data write first, then logic-driven flags override
	always_comb
	begin
		flags_next = flags_reg;
		if (is_flag_dst)
		begin
			flags_next[`BIT_SPARE_PAGE:`BIT_PAGE_LOW] = result[7:5];
			// Any flag-affecting op blocks the data write to all three flag bits
			if (!(upd_z || upd_dc || upd_c))
				flags_next[`BIT_ZERO:`BIT_CARRY] = result[`BIT_ZERO:`BIT_CARRY];
		end
		if (exec_i)
		begin
			if (upd_z)
				flags_next[`BIT_ZERO] = z_new;
			if (upd_dc)
				flags_next[`BIT_NIBBLE_CARRY] = dc_new;
			if (upd_c)
				flags_next[`BIT_CARRY] = c_new;
		end
		// Timeout/powerdown only follow their events, never the data path
		if (clrwdt_i)
			flags_next[`BIT_TIMEOUT:`BIT_POWERDOWN] = 2'h3;
		else if (sleep_i)
			flags_next[`BIT_TIMEOUT:`BIT_POWERDOWN] = 2'h2;
		if (wdt_timeout_i)
			flags_next[`BIT_TIMEOUT] = 1'b0;
	end

	// Flag register; arithmetic flags undefined at reset, zeroed here for X-safety
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			flags_reg <= {`PAGE_BITS_RESET, `SLEEP_FLAGS_RESET, `ARITH_FLAGS_RESET};
		else
			flags_reg <= flags_next;
	end

	// Accumulator update when destination bit is 0 and the op is not move to file or a bit op
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			acc_reg <= 8'h00;
		else if (exec_i && !dst_file)
			acc_reg <= result;
	end

	// File write port; flag register writes stay local
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			we_reg    <= 1'b0;
			wdata_reg <= 8'h00;
			waddr_reg <= 5'h00;
		end
		else
		begin
			we_reg    <= exec_i && dst_file && !use_const_i && !is_flag_dst;
			wdata_reg <= result;
			waddr_reg <= file_addr_i;
		end
	end

	// Page base from the two select bits, 512 words each
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			page_reg <= 11'h000;
		else
			page_reg <= {flags_next[`BIT_PAGE_HIGH:`BIT_PAGE_LOW], 9'h000};
	end

	assign acc_o        = acc_reg;
	assign flags_o      = flags_reg;
	assign file_wdata_o = wdata_reg;
	assign file_we_o    = we_reg;
	assign file_waddr_o = waddr_reg;
	assign page_base_o  = page_reg;

	sequence sub_issued;
		exec_i && op_i == OP_SUB && !use_const_i && !dst_file;
	endsequence

	sub_result_a: assert property (@(posedge clk_i) disable iff (srst_i)
		sub_issued |=> acc_reg == $past(opnd) - $past(acc_reg))
		else $error("subtract result wrong");
	sub_borrow_a: assert property (@(posedge clk_i) disable iff (srst_i)
		sub_issued |=> flags_reg[0] == ($past(opnd) >= $past(acc_reg)))
		else $error("subtract carry not inverted borrow");
	add_carry_a: assert property (@(posedge clk_i) disable iff (srst_i)
		exec_i && op_i == OP_ADD |=> flags_reg[0] ==
		(({1'b0, $past(opnd)} + {1'b0, $past(acc_reg)}) > 9'h0ff))
		else $error("add carry wrong");
	add_nibble_a: assert property (@(posedge clk_i) disable iff (srst_i)
		exec_i && op_i == OP_ADD |=> flags_reg[1] ==
		(({1'b0, $past(opnd[3:0])} + {1'b0, $past(acc_reg[3:0])}) > 5'h0f))
		else $error("nibble carry wrong");
	zero_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
		exec_i && upd_z |=> flags_reg[2] == ($past(result) == 8'h00))
		else $error("zero flag wrong");
	topd_locked_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!clrwdt_i && !sleep_i && !wdt_timeout_i |=> $stable(flags_reg[4:3]))
		else $error("timeout or powerdown changed by write");
	clear_flags_a: assert property (@(posedge clk_i) disable iff (srst_i)
		is_flag_dst && op_i == OP_CLR && !clrwdt_i && !sleep_i && !wdt_timeout_i
		|=> flags_reg[7:5] == 3'h0 && flags_reg[2] && flags_reg[1:0] == $past(flags_reg[1:0]))
		else $error("clear of flag register wrong");
	reset_value_a: assert property (@(posedge clk_i)
		srst_i |=> flags_reg[7:3] == 5'h03)
		else $error("flag register reset value wrong");
	flag_no_store_a: assert property (@(posedge clk_i) disable iff (srst_i)
		is_flag_dst |=> !file_we_o)
		else $error("flag register write leaked to file");
	page_base_a: assert property (@(posedge clk_i) disable iff (srst_i)
		##1 page_base_o == {flags_reg[6:5], 9'h000})
		else $error("page base mismatch");
	// A carry-only op aimed at the flag register must leave nibble carry alone
	flag_write_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
		is_flag_dst && upd_c && !upd_dc |=> flags_reg[1] == $past(flags_reg[1]))
		else $error("flag bit written by flag-affecting op");
	acc_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		exec_i && dst_file |=> $stable(acc_reg))
		else $error("accumulator changed by file-destination op");

endmodule

`default_nettype wire

// >>> tb/file_mem_model.sv
/*
 * File register memory on the far side of the datapath.
 * Assumes a combinational read and a write on the strobe at the clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module file_mem_model
	import alu_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic [4:0]     addr_i,
	input  wire logic           we_i,
	input  wire logic [4:0]     waddr_i,
	input  wire alu_pkg::byte_t wdata_i,
	output alu_pkg::byte_t      rdata_o
);
	byte_t mem [32];
	// Each cell starts at its own address, so the expected sums are easy to derive
	initial
	begin
		for (int i = 0; i < 32; i++)
			mem[i] = byte_t'(i);
	end
	// File operand read back in the same cycle
	assign rdata_o = mem[addr_i];
	// Write at each clock edge while the strobe is high
	always @(posedge clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for the datapath and the condition-flag register.
 * Assumes the file memory model and a 100 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import alu_pkg::*;
	logic       clk_i = 0, srst_i = 1, exec_i = 0, use_const_i = 0;
	logic       dest_file_i = 0, wdt_timeout_i = 0, sleep_i = 0, clrwdt_i = 0;
	alu_op_e    op_i = OP_ADD;
	byte_t      const_i = 8'h00, file_rdata_i, acc_o, flags_o, file_wdata_o;
	logic [4:0] file_addr_i = 5'h00, file_waddr_o;
	logic [2:0] bit_sel_i = 3'h0;
	logic       file_we_o;
	logic [10:0] page_base_o;
	int         n_mismatch = 0, n_compared = 0;
	// Free-running clock
	always #5 clk_i = ~clk_i;
	alu_status_flags alu_status_flags_inst (.clk_i, .srst_i, .exec_i, .op_i,
		.use_const_i, .const_i, .file_addr_i, .file_rdata_i, .dest_file_i,
		.bit_sel_i, .wdt_timeout_i, .sleep_i, .clrwdt_i, .acc_o, .flags_o,
		.file_wdata_o, .file_we_o, .file_waddr_o, .page_base_o);
	file_mem_model file_mem_model_inst (.clk_i, .addr_i(file_addr_i),
		.we_i(file_we_o), .waddr_i(file_waddr_o), .wdata_i(file_wdata_o),
		.rdata_o(file_rdata_i));
	// Shared compare
	task chk(input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One op per cycle; exec stays high so calls run back to back
	task step(input alu_op_e op, input logic [4:0] a, input logic d,
		input logic [2:0] b, input logic u, input byte_t k, input byte_t r,
		input byte_t fl, input logic we);
		op_i = op;
		file_addr_i = a;
		dest_file_i = d;
		bit_sel_i = b;
		use_const_i = u;
		const_i = k;
		exec_i = 1;
		@(negedge clk_i);
		chk(flags_o, fl);
		chk(file_we_o, we);
		if (we)
		begin
			chk(file_wdata_o, r);
			chk(file_waddr_o, a);
		end
		else if (!d || u)
			chk(acc_o, r);
	endtask
	task idle(input int n);
		exec_i = 0;
		repeat (n) @(negedge clk_i);
	endtask
	// Event pulse on {timeout, sleep, clear-watchdog}
	task pulse(input logic [2:0] ev, input byte_t fl);
		exec_i = 0;
		{wdt_timeout_i, sleep_i, clrwdt_i} = ev;
		@(negedge clk_i);
		{wdt_timeout_i, sleep_i, clrwdt_i} = 3'h0;
		@(negedge clk_i);
		chk(flags_o, fl);
	endtask
	task t_reset;
		chk(flags_o, 8'h18);
		chk(acc_o, 8'h00);
		chk(page_base_o, 11'h000);
	endtask
	// File minus accumulator, with and without borrow, both destinations
	task t_sub;
		step(OP_MOVF, 5'h02, 0, 0, 0, 0, 8'h02, 8'h18, 0);
		step(OP_SUB, 5'h05, 1, 0, 0, 0, 8'h03, 8'h1b, 1);
		step(OP_SUB, 5'h02, 1, 0, 0, 0, 8'h00, 8'h1f, 1);
		step(OP_SUB, 5'h01, 0, 0, 0, 0, 8'hff, 8'h18, 0);
	endtask
	// Carry out of bit 7 and out of the low nibble
	task t_add;
		step(OP_ADD, 5'h01, 0, 0, 0, 0, 8'h00, 8'h1f, 0);
		step(OP_ADD, 5'h00, 0, 0, 1, 8'h0f, 8'h0f, 8'h18, 0);
		step(OP_ADD, 5'h00, 0, 0, 1, 8'h01, 8'h10, 8'h1a, 0);
	endtask
	// Flag register as destination: logic wins, status bits hold
	task t_flagreg;
		step(OP_CLR, 5'h03, 1, 0, 0, 0, 0, 8'h1e, 0);
		step(OP_MOVW, 5'h03, 1, 0, 0, 0, 0, 8'h18, 0);
	endtask
	// Page select codes 11 and 10
	task t_page;
		step(OP_BSET, 5'h03, 1, 3'h6, 0, 0, 0, 8'h58, 0);
		step(OP_BSET, 5'h03, 1, 3'h5, 0, 0, 0, 8'h78, 0);
		idle(2);
		chk(page_base_o, 11'h600);
		step(OP_BCLR, 5'h03, 1, 3'h5, 0, 0, 0, 8'h58, 0);
		step(OP_BCLR, 5'h03, 1, 3'h4, 0, 0, 0, 8'h58, 0);
		idle(2);
		chk(page_base_o, 11'h400);
	endtask
	// Sleep, time-out and clear events, then a second reset
	task t_events;
		pulse(3'b010, 8'h50);
		pulse(3'b100, 8'h40);
		pulse(3'b011, 8'h58);
		srst_i = 1;
		@(negedge clk_i);
		srst_i = 0;
		@(negedge clk_i);
		t_reset;
	endtask
	// Logic, rotate, swap, complement, inc/dec, move, rotate into flag register
	task t_logic;
		step(OP_MOVF, 5'h00, 0, 3'h0, 1, 8'hc3, 8'hc3, 8'h18, 0);
		step(OP_AND, 5'h00, 0, 3'h0, 1, 8'h0f, 8'h03, 8'h18, 0);
		step(OP_XOR, 5'h00, 0, 3'h0, 1, 8'h03, 8'h00, 8'h1c, 0);
		step(OP_OR, 5'h00, 0, 3'h0, 1, 8'h81, 8'h81, 8'h18, 0);
		step(OP_RLF, 5'h00, 0, 3'h0, 1, 8'h81, 8'h02, 8'h19, 0);
		step(OP_RRF, 5'h00, 0, 3'h0, 1, 8'h02, 8'h81, 8'h18, 0);
		step(OP_SWAP, 5'h05, 1, 3'h0, 0, 8'h00, 8'h30, 8'h18, 1);
		step(OP_COMF, 5'h07, 0, 3'h0, 0, 8'h00, 8'hf8, 8'h18, 0);
		step(OP_INC, 5'h00, 0, 3'h0, 1, 8'hff, 8'h00, 8'h1c, 0);
		step(OP_DEC, 5'h00, 0, 3'h0, 1, 8'h01, 8'h00, 8'h1c, 0);
		step(OP_MOVW, 5'h09, 1, 3'h0, 0, 8'h00, 8'h00, 8'h1c, 1);
		step(OP_RLF, 5'h03, 1, 3'h0, 0, 8'h00, 8'h00, 8'h3c, 0);
		chk(page_base_o, 11'h200);
	endtask
	task print_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence after 12 cycles of reset
	initial
	begin
		repeat (12) @(negedge clk_i);
		srst_i = 0;
		t_reset;
		t_sub;
		t_add;
		t_flagreg;
		t_page;
		t_events;
		t_logic;
		print_verdict;
	end
	// Run needs under a hundred cycles; this cuts a hang short
	initial
	begin
		#20000;
		n_mismatch++;
		print_verdict;
	end
endmodule
`default_nettype wire
